// [hdl/cpw_ctrl.sv]
// Charge port wake control: auto charge step, wake on USB recognition, power wake and APB registers.
//
// Behaviour
// - In auto dedicated charge mode the lines are shorted and held at the low level for a fixed time, then only shorted.
// - The lines stay connected for wake only on mode changes 111 to 011 and 010 to 011, whatever the limit select.
// - A 110 to 011 change gives no wake connection, and a passing 111 leads to output discharge and the 111 state.
// - In standard or charging downstream modes an idle high D- means low speed, an idle high D+ means full speed.
// - A D+ attach whose D+ later falls is taken as high speed and never as a full speed wake source.
// - After a wake event no deadline applies to the return of the mode pins from auto mode.
// - Power wake runs only in setting 0011 and holds status low while a load charges.
// - In power wake, current under 45 mA for over 15 s selects the 55 mA limit and releases status high.
// - In the released state a load that hits the 55 mA limit drives status low again.
// - After status is driven low again the output is discharged over 2 s, then the high limit is used.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cpw_ctrl import cpw_pkg::*; #(
  parameter int unsigned TICK_DIVIDE = TICK_DIV,
  parameter int unsigned LOW_TICKS = LOW_LEVEL_TICKS,
  parameter int unsigned MEMO_TICKS = FS_MEMO_TICKS,
  parameter int unsigned IDLE_TICKS = IDLE_LOAD_TICKS,
  parameter int unsigned DISCH_TICKS = DISCHARGE_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mode_select_pin_a,
  input wire logic mode_select_pin_b,
  input wire logic mode_select_pin_c,
  input wire logic limit_select_input,
  input wire logic dp_high,
  input wire logic dm_high,
  input wire logic load_below_45ma,
  input wire logic load_at_55ma_limit,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cpw_port_ctl_t port_ctl,
  output logic status_n,
  output logic irq
);
  logic [3:0] pins_s1_reg;
  logic [3:0] pins_reg;
  logic [1:0] lines_s1_reg;
  logic [1:0] lines_reg;
  logic [2:0] mode_reg;
  logic [2:0] mode_prev_reg;
  logic [3:0] setting;
  logic tick;
  logic [TICK_CNT_W-1:0] auto_cnt_reg;
  logic [TICK_CNT_W-1:0] memo_cnt_reg;
  logic [TICK_CNT_W-1:0] pw_cnt_reg;
  cpw_auto_t auto_reg;
  cpw_pw_t pw_reg;
  logic ls_seen_reg;
  logic fs_seen_reg;
  logic hs_seen_reg;
  logic fs_valid_reg;
  logic wake_hold_reg;
  logic disch_111_reg;
  logic std_mode;
  logic [31:0] ctrl_reg;
  logic [EV_W-1:0] irq_stat_reg;
  logic [EV_W-1:0] irq_mask_reg;
  logic [EV_W-1:0] events;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata_next;

  // Pins come from another domain, so two flops precede any logic.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pins_s1_reg <= 4'h0;
      pins_reg <= 4'h0;
      lines_s1_reg <= 2'h0;
      lines_reg <= 2'h0;
    end else begin
      pins_s1_reg <= {mode_select_pin_a, mode_select_pin_b, mode_select_pin_c, limit_select_input};
      pins_reg <= pins_s1_reg;
      lines_s1_reg <= {dp_high, dm_high};
      lines_reg <= lines_s1_reg;
    end
  end

  // The setting reads as the three mode pins followed by the limit select, so power wake is 001 with limit high.
  assign setting = pins_reg;

  cpw_tick #(.DIV(TICK_DIVIDE)) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= 3'h0;
      mode_prev_reg <= 3'h0;
    end else begin
      mode_prev_reg <= mode_reg;
      mode_reg <= pins_reg[3:1];
    end
  end

  assign std_mode = (mode_reg == MODE_CDP) || (mode_reg == MODE_STANDARD_PORT_VARIANT_ONE) || (mode_reg == MODE_SDP1B);

  // Auto mode low level step before the shorted scheme.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      auto_reg <= CPW_AUTO_IDLE;
      auto_cnt_reg <= '0;
    end else if (mode_reg != MODE_AUTO || wake_hold_reg) begin
      auto_reg <= CPW_AUTO_IDLE;
      auto_cnt_reg <= '0;
    end else begin
      unique case (auto_reg)
        CPW_AUTO_IDLE: begin
          auto_reg <= CPW_AUTO_LOW;
          auto_cnt_reg <= '0;
        end
        CPW_AUTO_LOW: begin
          if (tick) begin
            auto_cnt_reg <= auto_cnt_reg + 1'b1;
          end
          if (auto_cnt_reg >= TICK_CNT_W'(LOW_TICKS)) begin
            auto_reg <= CPW_AUTO_SHORT;
          end
        end
        CPW_AUTO_SHORT: begin
          auto_reg <= CPW_AUTO_SHORT;
        end
        default: begin
          auto_reg <= CPW_AUTO_IDLE;
        end
      endcase
    end
  end

  // Device recognition while in standard or charging downstream modes.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ls_seen_reg <= 1'b0;
      fs_seen_reg <= 1'b0;
      hs_seen_reg <= 1'b0;
      fs_valid_reg <= 1'b0;
      memo_cnt_reg <= '0;
    end else if (std_mode) begin
      ls_seen_reg <= lines_reg[0] && !lines_reg[1];
      if (lines_reg[1] && !lines_reg[0] && !fs_seen_reg) begin
        fs_seen_reg <= 1'b1;
        memo_cnt_reg <= '0;
      end else if (fs_seen_reg && !lines_reg[1]) begin
        hs_seen_reg <= 1'b1;
        fs_seen_reg <= 1'b0;
        fs_valid_reg <= 1'b0;
      end else if (fs_seen_reg && tick && !fs_valid_reg) begin
        memo_cnt_reg <= memo_cnt_reg + 1'b1;
        // A full speed device is only trusted after it stayed attached long enough.
        fs_valid_reg <= (memo_cnt_reg >= TICK_CNT_W'(MEMO_TICKS - 1)) && !hs_seen_reg;
      end
      if (!lines_reg[1] && !lines_reg[0] && !fs_seen_reg) begin
        hs_seen_reg <= 1'b0;
      end
    end
  end

  // Wake hold: only 111 to 011 and 010 to 011 keep the lines; no timeout ever ends it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_hold_reg <= 1'b0;
    end else if (mode_reg == MODE_AUTO) begin
      if (mode_prev_reg != MODE_AUTO) begin
        wake_hold_reg <= ((mode_prev_reg == MODE_CDP) || (mode_prev_reg == MODE_STANDARD_PORT_VARIANT_ONE))
          && (ls_seen_reg || fs_valid_reg);
      end
    end else begin
      wake_hold_reg <= 1'b0;
    end
  end

  // A passing 111 is a real 111 command and discharges the output.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      disch_111_reg <= 1'b0;
    end else begin
      disch_111_reg <= (mode_reg == MODE_CDP) && (mode_prev_reg == MODE_SDP1B);
    end
  end

  // Power wake sequence.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pw_reg <= CPW_PW_OFF;
      pw_cnt_reg <= '0;
    end else if (setting != MODE_PWAKE) begin
      pw_reg <= CPW_PW_OFF;
      pw_cnt_reg <= '0;
    end else begin
      unique case (pw_reg)
        CPW_PW_OFF: begin
          pw_reg <= CPW_PW_CHARGE;
          pw_cnt_reg <= '0;
        end
        CPW_PW_CHARGE: begin
          if (!load_below_45ma) begin
            pw_cnt_reg <= '0;
          end else if (pw_cnt_reg > TICK_CNT_W'(IDLE_TICKS)) begin
            pw_reg <= CPW_PW_IDLE;
            pw_cnt_reg <= '0;
          end else if (tick) begin
            pw_cnt_reg <= pw_cnt_reg + 1'b1;
          end
        end
        CPW_PW_IDLE: begin
          if (load_at_55ma_limit) begin
            pw_reg <= CPW_PW_DISCH;
            pw_cnt_reg <= '0;
          end
        end
        CPW_PW_DISCH: begin
          if (pw_cnt_reg >= TICK_CNT_W'(DISCH_TICKS)) begin
            pw_reg <= CPW_PW_CHARGE;
            pw_cnt_reg <= '0;
          end else if (tick) begin
            pw_cnt_reg <= pw_cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_n <= 1'b1;
      port_ctl <= '0;
    end else begin
      status_n <= !((pw_reg == CPW_PW_CHARGE) || (pw_reg == CPW_PW_DISCH));
      // The auto state lags the mode by a cycle, so a connected port must mask it or the lines short while in use.
      port_ctl.short_lines <= (auto_reg != CPW_AUTO_IDLE) && ctrl_reg[0] && !std_mode && !wake_hold_reg;
      port_ctl.pull_low_level <= (auto_reg == CPW_AUTO_LOW) && ctrl_reg[0] && !std_mode && !wake_hold_reg;
      port_ctl.lines_connected <= std_mode || wake_hold_reg;
      port_ctl.discharge <= (pw_reg == CPW_PW_DISCH) || disch_111_reg;
      port_ctl.limit_55ma <= (pw_reg == CPW_PW_IDLE);
      port_ctl.limit_high <= (pw_reg == CPW_PW_CHARGE) || (setting != MODE_PWAKE);
    end
  end

  // Events for software; a set in the clearing cycle wins.
  assign events = {
    (pw_reg == CPW_PW_IDLE) && load_at_55ma_limit,
    (pw_reg == CPW_PW_CHARGE) && load_below_45ma && (pw_cnt_reg > TICK_CNT_W'(IDLE_TICKS)),
    std_mode && fs_seen_reg && !lines_reg[1],
    std_mode && !fs_valid_reg && fs_seen_reg && tick && (memo_cnt_reg >= TICK_CNT_W'(MEMO_TICKS - 1)),
    std_mode && !ls_seen_reg && lines_reg[0] && !lines_reg[1]
  };

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= '0;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      ctrl_reg <= pwdata;
    end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
      irq_mask_reg <= pwdata[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else if (wr_en && paddr == ADDR_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[EV_W-1:0]) | events;
    end else begin
      irq_stat_reg <= irq_stat_reg | events;
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    unique case (paddr)
      ADDR_CTRL: rdata_next = ctrl_reg;
      ADDR_STATE: rdata_next = {17'h0, setting, 2'h0, wake_hold_reg, fs_valid_reg, hs_seen_reg,
        ls_seen_reg, fs_seen_reg, auto_reg, pw_reg};
      ADDR_IRQ_STAT: rdata_next = {27'h0, irq_stat_reg};
      ADDR_IRQ_MASK: rdata_next = {27'h0, irq_mask_reg};
      default: rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      prdata <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule : cpw_ctrl
`default_nettype wire

// [hdl/cpw_pkg.sv]
// Package of constants, types and register map for the charge port wake control block.
package cpw_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned LOW_LEVEL_MS = 1200;
  localparam int unsigned LOW_LEVEL_TICKS = LOW_LEVEL_MS * TICK_HZ / 1000;
  localparam int unsigned FS_MEMO_S = 60;
  localparam int unsigned FS_MEMO_TICKS = FS_MEMO_S * TICK_HZ;
  localparam int unsigned IDLE_LOAD_S = 15;
  localparam int unsigned IDLE_LOAD_TICKS = IDLE_LOAD_S * TICK_HZ;
  localparam int unsigned DISCHARGE_S = 2;
  localparam int unsigned DISCHARGE_TICKS = DISCHARGE_S * TICK_HZ + 1;
  localparam int unsigned TICK_CNT_W = 20;
  localparam logic [2:0] MODE_CDP = 3'h7;
  localparam logic [2:0] MODE_STANDARD_PORT_VARIANT_ONE = 3'h2;
  localparam logic [2:0] MODE_SDP1B = 3'h6;
  localparam logic [2:0] MODE_AUTO = 3'h3;
  localparam logic [3:0] MODE_PWAKE = 4'h3;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int unsigned EV_LS = 0;
  localparam int unsigned EV_FS = 1;
  localparam int unsigned EV_HS = 2;
  localparam int unsigned EV_PW_REL = 3;
  localparam int unsigned EV_PW_ASRT = 4;
  localparam int unsigned EV_W = 5;
  typedef enum logic [1:0] {
    CPW_AUTO_IDLE = 2'b00,
    CPW_AUTO_LOW = 2'b01,
    CPW_AUTO_SHORT = 2'b10
  } cpw_auto_t;
  typedef enum logic [1:0] {
    CPW_PW_OFF = 2'b00,
    CPW_PW_CHARGE = 2'b01,
    CPW_PW_IDLE = 2'b10,
    CPW_PW_DISCH = 2'b11
  } cpw_pw_t;
  typedef struct packed {
    logic short_lines;
    logic pull_low_level;
    logic lines_connected;
    logic discharge;
    logic limit_55ma;
    logic limit_high;
  } cpw_port_ctl_t;
endpackage : cpw_pkg

// [hdl/cpw_tick.sv]
// Millisecond tick divider for the charge port wake block.
`timescale 1ns/1ps
`default_nettype none
module cpw_tick import cpw_pkg::*; #(
  parameter int unsigned DIV = TICK_DIV
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] div_reg;
  always_ff @(posedge ref_clk) begin
    if (rst || div_reg == DIV - 1) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (div_reg == DIV - 1);
    end
  end
endmodule : cpw_tick
`default_nettype wire

// [tb/cpw_ctrl_assertions.sv]
// Checker of port control and status timing for the charge port wake block.
`timescale 1ns/1ps
`default_nettype none
module cpw_ctrl_assertions import cpw_pkg::*; #(
  parameter int unsigned TICK_DIVIDE = TICK_DIV,
  parameter int unsigned LOW_TICKS = LOW_LEVEL_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mode_select_pin_a,
  input wire logic mode_select_pin_b,
  input wire logic mode_select_pin_c,
  input wire logic limit_select_input,
  input wire logic load_below_45ma,
  input wire logic status_n,
  input wire cpw_port_ctl_t port_ctl
);
  localparam int LO_B = (LOW_TICKS - 1) * TICK_DIVIDE;
  localparam int HI_B = (LOW_TICKS + 1) * TICK_DIVIDE + 4;
  wire logic [3:0] setting = {mode_select_pin_a, mode_select_pin_b, mode_select_pin_c, limit_select_input};
  logic [31:0] low_cnt;
  // The step length is judged at its end, so a tick phase slip of one tick is tolerated.
  always_ff @(posedge ref_clk) begin
    if (rst || !port_ctl.pull_low_level) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= low_cnt + 32'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  pull_short_a: assert property (port_ctl.pull_low_level |-> port_ctl.short_lines)
    else $error("low level step without shorted lines");
  low_len_a: assert property ($fell(port_ctl.pull_low_level) && port_ctl.short_lines |->
    low_cnt >= LO_B && low_cnt <= HI_B) else $error("low level step length wrong");
  short_conn_a: assert property (port_ctl.short_lines |-> !port_ctl.lines_connected)
    else $error("lines shorted while connected");
  pw_mode_a: assert property ((setting != 4'h3) [*8] |=> status_n)
    else $error("status low outside power wake");
  release_a: assert property ($rose(status_n) && setting == 4'h3 && $past(setting, 6) == 4'h3 |->
    port_ctl.limit_55ma && $past(load_below_45ma, 2)) else $error("release without idle load");
  limit_low_a: assert property (port_ctl.limit_55ma |-> status_n && !port_ctl.limit_high)
    else $error("low limit while status low");
  reassert_a: assert property ($fell(status_n) && $past(port_ctl.limit_55ma) |-> ##[0:2] port_ctl.discharge)
    else $error("no discharge after reassert");
  disch_end_a: assert property ($fell(port_ctl.discharge) && !status_n |-> port_ctl.limit_high)
    else $error("switch back on without high limit");
endmodule : cpw_ctrl_assertions
bind cpw_ctrl cpw_ctrl_assertions #(.TICK_DIVIDE(TICK_DIVIDE), .LOW_TICKS(LOW_TICKS)) chk_i (.*);
`default_nettype wire

// [tb/cpw_usb_dev.sv]
// Model of the attached USB device and of its load current.
`timescale 1ns/1ps
`default_nettype none
module cpw_usb_dev import cpw_pkg::*; #(
  parameter int unsigned HS_UP = 12
) (
  input wire logic ref_clk,
  input wire logic [1:0] kind,
  input wire logic [7:0] load_ma,
  input wire cpw_port_ctl_t port_ctl,
  output logic dp_high,
  output logic dm_high,
  output logic load_below_45ma,
  output logic load_at_55ma_limit
);
  logic [7:0] up_cnt = 8'h00;
  // A high speed device drops its D+ pull-up once negotiation is over.
  always_ff @(posedge ref_clk) begin
    up_cnt <= (kind == 2'h3) ? up_cnt + {7'h0, up_cnt < HS_UP} : 8'h00;
  end
  assign dm_high = kind == 2'h1;
  assign dp_high = kind == 2'h2 || (kind == 2'h3 && up_cnt < HS_UP);
  assign load_below_45ma = load_ma < 8'h2d;
  assign load_at_55ma_limit = port_ctl.limit_55ma && load_ma > 8'h37;
endmodule : cpw_usb_dev
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the charge port wake control block.
`timescale 1ns/1ps
`default_nettype none
module testbench import cpw_pkg::*;;
  localparam int D = 4, LT = 3, MT = 5, IT = 5, DT = 3;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, status_n, irq, dp, dm, lo45, at55;
  logic [7:0] paddr = 8'h00, load = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] sel = 4'hf;
  logic [1:0] kind = 2'h0;
  cpw_port_ctl_t pc;
  int n_mismatch = 0, checks = 0, cycles = 0;
  cpw_ctrl #(.TICK_DIVIDE(D), .LOW_TICKS(LT), .MEMO_TICKS(MT), .IDLE_TICKS(IT), .DISCH_TICKS(DT)) cpw_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .mode_select_pin_a(sel[2]), .mode_select_pin_b(sel[1]),
    .mode_select_pin_c(sel[0]), .limit_select_input(sel[3]), .dp_high(dp), .dm_high(dm),
    .load_below_45ma(lo45), .load_at_55ma_limit(at55), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_ctl(pc), .status_n(status_n), .irq(irq));
  cpw_usb_dev cpw_usb_dev_i (.ref_clk(ref_clk), .kind(kind), .load_ma(load), .port_ctl(pc),
    .dp_high(dp), .dm_high(dm), .load_below_45ma(lo45), .load_at_55ma_limit(at55));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // An idle edge follows each transfer so the next setup never lands in the same time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd
  task automatic t_reset;
    chk("status_n", status_n, 1'h1);
    chk("port_ctl", pc, 6'h09);
    chk("irq", irq, 1'h0);
    chk("pslverr", pslverr, 1'h0);
    rd("ctrl", ADDR_CTRL, CTRL_RESET);
    rd("mask", ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, 8'h10, 32'h5a);
    rd("unmapped", 8'h10, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1f);
    rd("mask", ADDR_IRQ_MASK, 32'h1f);
    $display("test reset done");
  endtask : t_reset
  task automatic t_auto;
    sel <= 4'hb;
    cyc(8);
    chk("short", pc.short_lines, 1'h1);
    chk("low level", pc.pull_low_level, 1'h1);
    cyc(LT * D + 8);
    chk("short", pc.short_lines, 1'h1);
    chk("low level", pc.pull_low_level, 1'h0);
    sel <= 4'hf;
    cyc(8);
    $display("test auto done");
  endtask : t_auto
  task automatic t_wake;
    kind <= 2'h1;
    cyc(10);
    rd("ls event", ADDR_IRQ_STAT, 32'h1);
    chk("irq", irq, 1'h1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    cyc(3);
    chk("irq", irq, 1'h0);
    sel <= 4'hb;
    cyc(8);
    chk("connected", pc.lines_connected, 1'h1);
    cyc(60);
    chk("connected", pc.lines_connected, 1'h1);
    sel <= 4'h2;
    cyc(8);
    sel <= 4'h3;
    cyc(8);
    chk("connected", pc.lines_connected, 1'h1);
    sel <= 4'he;
    cyc(8);
    sel <= 4'hb;
    cyc(8);
    chk("connected", pc.lines_connected, 1'h0);
    sel <= 4'hf;
    kind <= 2'h0;
    cyc(8);
    $display("test wake done");
  endtask : t_wake
  task automatic t_fs_hs;
    apb(1'b1, ADDR_IRQ_STAT, 32'h1f);
    kind <= 2'h2;
    // The full speed device stays attached past the memory time before any sleep.
    cyc(MT * D + 20);
    rd("fs event", ADDR_IRQ_STAT, 32'h2);
    kind <= 2'h0;
    cyc(8);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1f);
    kind <= 2'h3;
    cyc(MT * D + 20);
    rd("hs event", ADDR_IRQ_STAT, 32'h4);
    kind <= 2'h0;
    $display("test fs hs done");
  endtask : t_fs_hs
  task automatic t_pw;
    apb(1'b1, ADDR_IRQ_STAT, 32'h1f);
    load <= 8'h64;
    sel <= 4'h9;
    cyc(8);
    chk("status_n", status_n, 1'h0);
    load <= 8'h0a;
    cyc(IT * D - 6);
    chk("status_n", status_n, 1'h0);
    cyc(20);
    chk("status_n", status_n, 1'h1);
    chk("limit 55", pc.limit_55ma, 1'h1);
    load <= 8'h64;
    cyc(6);
    chk("status_n", status_n, 1'h0);
    chk("discharge", pc.discharge, 1'h1);
    cyc(DT * D + 10);
    chk("discharge", pc.discharge, 1'h0);
    chk("limit high", pc.limit_high, 1'h1);
    rd("pw events", ADDR_IRQ_STAT, 32'h18);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    cyc(1);
    chk("irq", irq, 1'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1f);
    cyc(1);
    chk("irq", irq, 1'h1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h18);
    cyc(2);
    chk("irq", irq, 1'h0);
    sel <= 4'hf;
    cyc(10);
    chk("status_n", status_n, 1'h1);
    $display("test power wake done");
  endtask : t_pw
  initial begin
    cyc(8);
    rst <= 1'b0;
    cyc(8);
    t_reset();
    t_auto();
    t_wake();
    t_fs_hs();
    t_pw();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
